// ==== pkg/hmb_pkg.sv ====
/*
 * shared constants of the host mailbox interface: register offsets,
 * field positions, reset values, path lengths and message mode codes.
 * assumes both ends and the carrier import it whole.
 */
`default_nettype none
package hmb_pkg;
  // ----------------------------------------------------------------
  // register offsets on the host bus
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_MBX_DATA  = 4'h0;
  localparam logic [3:0] OFS_MBX_ADDR  = 4'h1;
  localparam logic [3:0] OFS_MSG_TYPE  = 4'h2;
  localparam logic [3:0] OFS_ACK_A     = 4'h3;
  localparam logic [3:0] OFS_ACK_B     = 4'h4;
  localparam logic [3:0] OFS_CTRL_LO   = 4'h5;
  localparam logic [3:0] OFS_CTRL_HI   = 4'h6;
  localparam logic [3:0] OFS_MASK_STAT = 4'h7;
  localparam logic [3:0] OFS_SRST      = 4'h8;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         SRST_BIT      = 0;
  localparam int         MASK_BIT      = 2;
  localparam int         ACK_BIT       = 0;
  localparam int         TXBUSY_BIT    = 1;
  localparam int         PSEL_LSB      = 6;
  localparam logic       MASK_RST      = 1'b0;
  localparam logic       SRST_RST      = 1'b0;
  // ----------------------------------------------------------------
  // mailbox and path sizes
  // ----------------------------------------------------------------
  localparam int         MBX_BYTES     = 253;
  localparam logic [7:0] MBX_LAST      = 8'hfc;
  localparam logic [7:0] MPL_PATH0     = 8'h3d;
  localparam logic [7:0] MPL_PATHN     = 8'hfd;
  localparam int         FIFO_WIDTH    = 9;
  localparam int         FIFO_DEPTH    = 4;
  // ----------------------------------------------------------------
  // path codes and message modes (mode values arbitrary)
  // ----------------------------------------------------------------
  localparam logic [1:0] PATH_MODEM    = 2'b01;
  localparam logic [1:0] PATH_RATE     = 2'b10;
  localparam logic [7:0] MODE_DATAMODEM   = 8'h20;
  localparam logic [7:0] MODE_RATE_ADAPT  = 8'h10;
endpackage
`default_nettype wire

// ==== pkg/hmb_bus_if.sv ====
/*
 * parallel host bus between host end and device end, with the
 * open-drain interrupt line resolved here from its enable.
 * assumes one clock and active-low asynchronous reset on both ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface hmb_bus_if (
  input wire logic clk_i,
  input wire logic resetn_i
);
  logic       sel;
  logic       wr;
  logic       rd;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       irq_oe;
  logic       irq_out;
  logic       irq_n;

  // open drain: pulled up unless the device drives low
  assign irq_n = irq_oe ? irq_out : 1'b1;

  modport dev  (input sel, wr, rd, addr, wdata, output rdata, irq_oe, irq_out);
  modport host (output sel, wr, rd, addr, wdata, input rdata, irq_n);
endinterface
`default_nettype wire

// ==== hw/hmb_device.sv ====
/*
 * device end of the host mailbox: register file, two mailboxes,
 * interrupt logic, and a small fifo toward the path buffers.
 * assumes the host drives one-cycle strobes on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module hmb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             clear_i,
  // fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
  } hmb_fifo_type;
  hmb_fifo_type r, n;
  logic push, pop;

  assign in_ready_o  = (r.count != (AW+1)'(DEPTH));
  assign out_valid_o = (r.count != '0);
  assign out_data_o  = r.mem[r.rptr];

  always_comb begin
    n    = r;
    push = in_valid_i & in_ready_o;
    pop  = out_valid_o & out_ready_i;
    if (push) begin
      n.mem[r.wptr] = in_data_i;
      n.wptr        = (r.wptr == AW'(DEPTH-1)) ? '0 : r.wptr + 1'b1;
    end
    if (pop) begin
      n.rptr = (r.rptr == AW'(DEPTH-1)) ? '0 : r.rptr + 1'b1;
    end
    n.count = r.count + (AW+1)'(push) - (AW+1)'(pop);
    if (clear_i) begin
      n = '0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule // hmb_fifo

module hmb_device
  import hmb_pkg::*;
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  // host bus
  hmb_bus_if.dev                   bus,
  // messages from the paths into the read mailbox
  input  wire logic                rx_valid_i,
  input  wire logic [7:0]          rx_byte_i,
  input  wire logic                rx_last_i,
  input  wire logic [7:0]          rx_type_i,
  input  wire logic [7:0]          rx_ctrl_hi_i,
  output logic                     rx_ready_o,
  // messages from the write mailbox toward the paths
  output logic [7:0]               tx_type_o,
  output logic [15:0]              tx_ctrl_o,
  output logic                     tx_valid_o,
  output logic [FIFO_WIDTH-1:0]    tx_data_o,
  input  wire logic                tx_ready_i,
  // free bytes in each path's external write buffer
  input  wire logic [3:0][8:0]     path_free_i,
  // internal reset seen by the rest of the core
  output logic                     core_reset_o
);
  typedef enum logic [1:0] {
    T_IDLE  = 2'b00,
    T_SEND  = 2'b01,
    T_CHECK = 2'b10
  } hmb_tx_state_type;

  typedef struct packed {
    logic [MBX_BYTES-1:0][7:0] rx_mem;
    logic [MBX_BYTES-1:0][7:0] tx_mem;
    logic [7:0]                mbx_addr;
    logic [7:0]                rx_type;
    logic [15:0]               rx_ctrl;
    logic [7:0]                rx_wptr;
    logic                      rx_ready;
    logic [15:0]               tx_ctrl;
    logic [7:0]                tx_type;
    logic [7:0]                tx_rptr;
    hmb_tx_state_type          tx_state;
    logic                      msg_pend;
    logic                      bufav_pend;
    logic                      mask;
    logic                      srst;
    logic                      irq_oe;
    logic [7:0]                rdata;
  } hmb_dev_type;

  localparam hmb_dev_type DEV_RST = '{mask: MASK_RST, srst: SRST_RST, tx_state: T_IDLE, default: '0};

  hmb_dev_type r, n;
  logic                  fifo_in_ready;
  logic                  fifo_push;
  logic [FIFO_WIDTH-1:0] fifo_in;
  logic [1:0]            tx_path;
  logic [7:0]            tx_mpl;
  logic [7:0]            addr_inc;
  logic                  bufav_set;
  logic                  keep_srst;
  logic [7:0]            keep_rdata;

  assign tx_path   = r.tx_type[PSEL_LSB +: 2];
  assign tx_mpl    = (tx_path == 2'b00) ? MPL_PATH0 : MPL_PATHN;
  assign addr_inc  = (r.mbx_addr == MBX_LAST) ? 8'h00 : r.mbx_addr + 8'h01;
  assign fifo_push = (r.tx_state == T_SEND);
  assign fifo_in   = {(r.tx_rptr == r.tx_ctrl[7:0] - 8'h01), r.tx_mem[r.tx_rptr]};

  // ----------------------------------------------------------------
  // buffer toward the external path fifos
  // ----------------------------------------------------------------
  hmb_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .clear_i     (r.srst),
    .in_valid_i  (fifo_push),
    .in_data_i   (fifo_in),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (tx_valid_o),
    .out_data_o  (tx_data_o),
    .out_ready_i (tx_ready_i)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n         = r;
    bufav_set = 1'b0;
    // read port: rx mailbox on the data address
    if (bus.sel && bus.rd) begin
      n.rdata = 8'h00;
      case (bus.addr)
        OFS_MBX_DATA: begin
          n.rdata    = r.rx_mem[r.mbx_addr];
          n.mbx_addr = addr_inc;
        end
        OFS_MBX_ADDR:  n.rdata = r.mbx_addr;
        OFS_MSG_TYPE:  n.rdata = r.rx_type;
        OFS_ACK_A:     n.rdata[ACK_BIT] = r.msg_pend;
        OFS_ACK_B: begin
          n.rdata[ACK_BIT]    = r.bufav_pend;
          n.rdata[TXBUSY_BIT] = (r.tx_state != T_IDLE);
        end
        OFS_CTRL_LO:   n.rdata = r.rx_ctrl[7:0];
        OFS_CTRL_HI:   n.rdata = r.rx_ctrl[15:8];
        OFS_MASK_STAT: n.rdata[MASK_BIT] = r.msg_pend | r.bufav_pend;
        OFS_SRST:      n.rdata[SRST_BIT] = r.srst;
        default:       n.rdata = 8'h00;
      endcase
    end
    // write port: tx mailbox on the data address
    if (bus.sel && bus.wr) begin
      case (bus.addr)
        OFS_MBX_DATA: begin
          n.tx_mem[r.mbx_addr] = bus.wdata;
          n.mbx_addr           = addr_inc;
        end
        OFS_MBX_ADDR:  n.mbx_addr = bus.wdata;
        OFS_MSG_TYPE: begin
          // type byte hands the message over; ignored while still sending
          if (r.tx_state == T_IDLE) begin
            n.tx_type  = bus.wdata;
            n.tx_rptr  = 8'h00;
            n.tx_state = (r.tx_ctrl[7:0] == 8'h00) ? T_CHECK : T_SEND;
          end
        end
        OFS_ACK_A: begin
          if (bus.wdata[ACK_BIT]) begin
            n.msg_pend = 1'b0;
          end
        end
        OFS_ACK_B: begin
          if (bus.wdata[ACK_BIT]) begin
            n.bufav_pend = 1'b0;
          end
        end
        OFS_CTRL_LO:   n.tx_ctrl[7:0]  = bus.wdata;
        OFS_CTRL_HI:   n.tx_ctrl[15:8] = bus.wdata;
        OFS_MASK_STAT: n.mask = bus.wdata[MASK_BIT];
        OFS_SRST:      n.srst = bus.wdata[SRST_BIT];
        default: ;
      endcase
    end
    // path side fills the read mailbox; held until acknowledged
    if (r.rx_ready && rx_valid_i) begin
      n.rx_mem[r.rx_wptr] = rx_byte_i;
      n.rx_wptr           = (r.rx_wptr == MBX_LAST) ? r.rx_wptr : r.rx_wptr + 8'h01;
      if (rx_last_i) begin
        n.rx_type  = rx_type_i;
        n.rx_ctrl  = {rx_ctrl_hi_i, r.rx_wptr + 8'h01};
        n.rx_wptr  = 8'h00;
        n.msg_pend = 1'b1;
      end
    end
    // stream the written message into the path buffer
    case (r.tx_state)
      T_IDLE: ;
      T_SEND: begin
        if (fifo_in_ready) begin
          n.tx_rptr = r.tx_rptr + 8'h01;
          if (fifo_in[FIFO_WIDTH-1]) begin
            n.tx_state = T_CHECK;
          end
        end
      end
      T_CHECK: begin
        // another message of the path's length must still fit
        bufav_set  = (path_free_i[tx_path] >= {1'b0, tx_mpl});
        n.tx_state = T_IDLE;
      end
      default: n.tx_state = T_IDLE;
    endcase
    // set wins over a clear in the same cycle
    if (bufav_set) begin
      n.bufav_pend = 1'b1;
    end
    n.rx_ready = ~n.msg_pend;
    // internal reset for as long as the bit stands
    if (r.srst) begin
      keep_srst  = n.srst;
      keep_rdata = n.rdata;
      n          = DEV_RST;
      n.srst     = keep_srst;
      n.rdata    = keep_rdata;
      n.rx_ready = 1'b0;
    end else begin
      keep_srst  = 1'b0;
      keep_rdata = 8'h00;
    end
    n.irq_oe = n.mask & (n.msg_pend | n.bufav_pend);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= DEV_RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.rdata    = r.rdata;
  assign bus.irq_oe   = r.irq_oe;
  assign bus.irq_out  = 1'b0;
  assign rx_ready_o   = r.rx_ready;
  assign tx_type_o    = r.tx_type;
  assign tx_ctrl_o    = r.tx_ctrl;
  assign core_reset_o = r.srst;
endmodule // hmb_device
`default_nettype wire

// ==== hw/hmb_host.sv ====
/*
 * host end of the mailbox bus: turns user commands into at most two
 * register accesses and returns read data.
 * assumes the device answers a read on the first cycle after the strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module hmb_host
  import hmb_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // device bus
  hmb_bus_if.host         bus,
  // user commands
  input  wire logic       cmd_valid_i,
  input  wire logic [1:0] cmd_op_i,
  input  wire logic       cmd_write_i,
  input  wire logic [3:0] cmd_addr_i,
  input  wire logic [7:0] cmd_wdata_i,
  input  wire logic [7:0] cmd_mbx_addr_i,
  output logic            cmd_ready_o,
  // answers
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_data_o,
  output logic            cmd_refused_o,
  output logic            irq_o
);
  typedef enum logic [1:0] {
    OP_REG   = 2'b00,
    OP_MBX   = 2'b01,
    OP_SRST  = 2'b10,
    OP_ACK   = 2'b11
  } hmb_op_type;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_ACC1 = 2'b01,
    H_ACC2 = 2'b10,
    H_READ = 2'b11
  } hmb_hstate_type;

  typedef struct packed {
    hmb_hstate_type state;
    logic           second;
    logic           is_read;
    logic [3:0]     addr2;
    logic [7:0]     wdata2;
    logic [7:0]     ctrl_hi;
    logic           modem_on;
    logic           sel;
    logic           wr;
    logic           rd;
    logic [3:0]     addr;
    logic [7:0]     wdata;
    logic           ready;
    logic           rsp_valid;
    logic [7:0]     rsp_data;
    logic           refused;
    logic           irq;
  } hmb_host_type;

  localparam hmb_host_type HOST_RST = '{state: H_IDLE, ready: 1'b1, default: '0};

  hmb_host_type r, n;
  hmb_op_type   op;
  logic [1:0]   wr_path;
  logic         bad_mode;

  assign op       = hmb_op_type'(cmd_op_i);
  assign wr_path  = cmd_wdata_i[PSEL_LSB +: 2];
  assign bad_mode = r.modem_on && (wr_path == PATH_RATE) && (r.ctrl_hi == MODE_RATE_ADAPT);

  always_comb begin
    n           = r;
    n.sel       = 1'b0;
    n.wr        = 1'b0;
    n.rd        = 1'b0;
    n.rsp_valid = 1'b0;
    n.refused   = 1'b0;
    n.irq       = ~bus.irq_n;
    case (r.state)
      H_IDLE: begin
        if (cmd_valid_i) begin
          n.is_read = (op == OP_REG || op == OP_MBX) && !cmd_write_i;
          n.second  = 1'b0;
          n.sel     = 1'b1;
          n.wr      = 1'b1;
          n.addr    = cmd_addr_i;
          n.wdata   = cmd_wdata_i;
          n.state   = H_ACC1;
          n.ready   = 1'b0;
          case (op)
            OP_REG: begin
              n.wr = cmd_write_i;
              n.rd = !cmd_write_i;
              if (cmd_write_i && cmd_addr_i == OFS_CTRL_HI) begin
                n.ctrl_hi = cmd_wdata_i;
              end
              if (cmd_write_i && cmd_addr_i == OFS_MSG_TYPE) begin
                if (bad_mode) begin
                  n.sel       = 1'b0;
                  n.wr        = 1'b0;
                  n.refused   = 1'b1;
                  n.rsp_valid = 1'b1;
                  n.state     = H_IDLE;
                  n.ready     = 1'b1;
                end else if (wr_path == PATH_MODEM) begin
                  n.modem_on = (r.ctrl_hi == MODE_DATAMODEM);
                end
              end
            end
            OP_MBX: begin
              // random access: new address before every byte
              n.addr   = OFS_MBX_ADDR;
              n.wdata  = cmd_mbx_addr_i;
              n.second = 1'b1;
              n.addr2  = OFS_MBX_DATA;
              n.wdata2 = cmd_wdata_i;
            end
            OP_SRST: begin
              n.addr   = OFS_SRST;
              n.wdata  = 8'h01;
              n.second = 1'b1;
              n.addr2  = OFS_SRST;
              n.wdata2 = 8'h00;
              n.modem_on = 1'b0;
            end
            OP_ACK: begin
              n.addr  = OFS_ACK_A;
              n.wdata = 8'h01;
            end
            default: ;
          endcase
        end
      end
      H_ACC1: begin
        if (r.second) begin
          n.sel   = 1'b1;
          n.wr    = !r.is_read;
          n.rd    = r.is_read;
          n.addr  = r.addr2;
          n.wdata = r.wdata2;
          n.state = H_ACC2;
        end else if (r.is_read) begin
          n.state = H_READ;
        end else begin
          n.rsp_valid = 1'b1;
          n.state     = H_IDLE;
          n.ready     = 1'b1;
        end
      end
      H_ACC2: begin
        if (r.is_read) begin
          n.state = H_READ;
        end else begin
          n.rsp_valid = 1'b1;
          n.state     = H_IDLE;
          n.ready     = 1'b1;
        end
      end
      H_READ: begin
        n.rsp_data  = bus.rdata;
        n.rsp_valid = 1'b1;
        n.state     = H_IDLE;
        n.ready     = 1'b1;
      end
      default: n.state = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= HOST_RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.sel       = r.sel;
  assign bus.wr        = r.wr;
  assign bus.rd        = r.rd;
  assign bus.addr      = r.addr;
  assign bus.wdata     = r.wdata;
  assign cmd_ready_o   = r.ready;
  assign rsp_valid_o   = r.rsp_valid;
  assign rsp_data_o    = r.rsp_data;
  assign cmd_refused_o = r.refused;
  assign irq_o         = r.irq;
endmodule // hmb_host
`default_nettype wire

// ==== verification/hmb_chk.sv ====
/* timing checks on the host mailbox bus.
   assumes it sits beside the bus instance and sees its plain signals. */
`timescale 1ns/1ps
`default_nettype none
module hmb_chk
  import hmb_pkg::*;
(
  // clock and reset
  input wire logic       clk_i,
  input wire logic       resetn_i,
  // bus signals
  input wire logic       sel,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       irq_oe,
  input wire logic       irq_out,
  input wire logic       irq_n
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ----
  // shadow of mask and soft reset bits
  // ----
  typedef struct packed {
    logic msk;
    logic srst;
  } hmb_shadow_type;
  hmb_shadow_type sh_r;
  hmb_shadow_type sh_nxt;
  always_comb begin
    sh_nxt = sh_r;
    if (sel && wr && addr == OFS_MASK_STAT) sh_nxt.msk = wdata[MASK_BIT];
    if (sel && wr && addr == OFS_SRST) sh_nxt.srst = wdata[SRST_BIT];
    // soft reset wins over a mask write
    if (sh_r.srst) sh_nxt.msk = MASK_RST;
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) sh_r <= '0;
    else sh_r <= sh_nxt;
  end
  // ----
  // assertions
  // ----
  sequence s_srst_held;
    sh_r.srst [*3];
  endsequence
  sequence s_srst_set;
    sel && wr && addr == OFS_SRST && wdata[SRST_BIT];
  endsequence
  a_mask_gates_irq: assert property (!sh_r.msk && !$past(sh_r.msk) |-> !irq_oe)
    else $error("interrupt line driven while masked");
  a_irq_open_drain: assert property (!irq_out && (irq_n == !irq_oe))
    else $error("interrupt line not open drain");
  a_pending_seen: assert property (sel && rd && addr == OFS_MASK_STAT && irq_oe |=> rdata[MASK_BIT])
    else $error("pending bit clear while interrupt driven");
  a_unmapped_zero: assert property (sel && rd && addr > OFS_SRST |=> rdata == 8'h00)
    else $error("unused offset reads nonzero");
  a_srst_readback: assert property (sel && rd && addr == OFS_SRST |=> rdata[SRST_BIT] == $past(sh_r.srst))
    else $error("soft reset bit lost");
  a_reset_masked: assert property ($rose(resetn_i) |-> !irq_oe [*2])
    else $error("interrupt not masked after reset");
  a_srst_silent: assert property (s_srst_held |-> !irq_oe)
    else $error("interrupt driven during soft reset");
  a_srst_release: assert property (s_srst_set |-> ##[1:40] (sel && wr && addr == OFS_SRST && !wdata[SRST_BIT]))
    else $error("soft reset never released");
endmodule // hmb_chk
`default_nettype wire

// ==== verification/hmb_tb_top.sv ====
/* bench: host end and device end on one bus, queue model of the mailboxes.
   assumes package, bus, both ends and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module hmb_tb_top
  import hmb_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        cv = 1'b0, cw = 1'b0, rxv = 1'b0, rxl = 1'b0, txr = 1'b0;
  logic [1:0]  cop = '0;
  logic [3:0]  ca = '0;
  logic [7:0]  cd = '0, cm = '0, rxb = '0, rxt = '0, rxh = '0, q, rspd, txt;
  logic        crdy, rspv, refd, irq, rxr, txv, crst, rf;
  logic [15:0] txc;
  logic [8:0]  txd;
  logic [3:0]  rv[5] = '{OFS_ACK_A, OFS_ACK_B, OFS_MASK_STAT, OFS_SRST, 4'hf};
  int          fails = 0, compares = 0, cyc = 0;
  int          mb[$];
  always #20 clk_i = ~clk_i;
  hmb_bus_if bus (.clk_i(clk_i), .resetn_i(resetn_i));
  hmb_host i_hmb_host (.clk_i(clk_i), .resetn_i(resetn_i), .bus(bus), .cmd_valid_i(cv), .cmd_op_i(cop),
    .cmd_write_i(cw), .cmd_addr_i(ca), .cmd_wdata_i(cd), .cmd_mbx_addr_i(cm), .cmd_ready_o(crdy),
    .rsp_valid_o(rspv), .rsp_data_o(rspd), .cmd_refused_o(refd), .irq_o(irq));
  hmb_device i_hmb_device (.clk_i(clk_i), .resetn_i(resetn_i), .bus(bus), .rx_valid_i(rxv), .rx_byte_i(rxb),
    .rx_last_i(rxl), .rx_type_i(rxt), .rx_ctrl_hi_i(rxh), .rx_ready_o(rxr), .tx_type_o(txt), .tx_ctrl_o(txc),
    .tx_valid_o(txv), .tx_data_o(txd), .tx_ready_i(txr), .path_free_i({4{9'h0fd}}), .core_reset_o(crst));
  hmb_chk i_hmb_chk (.clk_i(clk_i), .resetn_i(resetn_i), .sel(bus.sel), .wr(bus.wr), .rd(bus.rd),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .irq_oe(bus.irq_oe), .irq_out(bus.irq_out),
    .irq_n(bus.irq_n));
  // ----
  // tasks
  // ----
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic cmd(input logic [1:0] o, input logic w, input logic [3:0] a, input logic [7:0] d, m);
    @(posedge clk_i);
    {cv, cop, cw, ca, cd, cm} <= {1'b1, o, w, a, d, m};
    do @(negedge clk_i); while (!crdy);
    @(posedge clk_i);
    cv <= 1'b0;
    do @(negedge clk_i); while (!rspv);
    q = rspd;
    rf = refd;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] m, e);
    cmd(2'd0, 1'b0, a, 8'h00, 8'h00);
    chk(q & m, e);
  endtask
  task automatic rxmsg(input int n, input logic [7:0] t);
    mb.delete();
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      mb.push_back($urandom_range(255));
      {rxv, rxb, rxl, rxt} <= {1'b1, 8'(mb[i]), i == n - 1, t};
      do @(negedge clk_i); while (!rxr);
    end
    @(posedge clk_i);
    rxv <= 1'b0;
    rxb <= ~rxb;
  endtask
  task automatic txdrain(input int n);
    int k = 0;
    while (k < n) begin
      @(posedge clk_i);
      txr <= 1'($urandom_range(1));
      @(negedge clk_i);
      if (txv && txr) begin
        chk({txd[8], txd[7:0]} == {k == n - 1, 8'(mb[k])}, 8'h01);
        k++;
      end
    end
    @(posedge clk_i);
    txr <= 1'b0;
  endtask
  // hang guard, well above the few hundred cycles needed
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      $display("unexpected at %0t: run too long", $time);
      conclude();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(32'hbf19));
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    foreach (rv[i]) rdchk(rv[i], 8'hff, 8'h00);
    cmd(2'd0, 1'b1, OFS_MASK_STAT, 8'h04, 8'h00);
    rxh <= 8'($urandom_range(255));
    rxmsg(5, 8'h40);
    repeat (4) @(negedge clk_i);
    chk({7'h0, irq}, 8'h01);
    rdchk(OFS_MASK_STAT, 8'h04, 8'h04);
    rdchk(OFS_ACK_A, 8'h01, 8'h01);
    rdchk(OFS_CTRL_LO, 8'hff, 8'd5);
    rdchk(OFS_CTRL_HI, 8'hff, rxh);
    rdchk(OFS_MSG_TYPE, 8'hff, 8'h40);
    cmd(2'd1, 1'b0, OFS_MBX_DATA, 8'h00, 8'h00);
    chk(q, 8'(mb[0]));
    for (int i = 1; i < 5; i++) rdchk(OFS_MBX_DATA, 8'hff, 8'(mb[i]));
    cmd(2'd1, 1'b0, OFS_MBX_DATA, 8'h00, 8'h03);
    chk(q, 8'(mb[3]));
    cmd(2'd3, 1'b1, OFS_ACK_A, 8'h01, 8'h00);
    repeat (3) @(negedge clk_i);
    chk({6'h0, irq, rxr}, 8'h01);
    cmd(2'd0, 1'b1, OFS_MASK_STAT, 8'h00, 8'h00);
    mb.delete();
    for (int i = 0; i < 6; i++) begin
      mb.push_back($urandom_range(255));
      cmd(i == 0 ? 2'd1 : 2'd0, 1'b1, OFS_MBX_DATA, 8'(mb[i]), 8'h00);
    end
    cmd(2'd0, 1'b1, OFS_CTRL_LO, 8'd6, 8'h00);
    cmd(2'd0, 1'b1, OFS_CTRL_HI, MODE_DATAMODEM, 8'h00);
    cmd(2'd0, 1'b1, OFS_MSG_TYPE, 8'h40, 8'h00);
    chk(txt, 8'h40);
    chk(txc[15:8] ^ txc[7:0], MODE_DATAMODEM ^ 8'd6);
    rdchk(OFS_ACK_B, 8'h02, 8'h02);
    txdrain(6);
    repeat (4) @(negedge clk_i);
    rdchk(OFS_ACK_B, 8'h03, 8'h01);
    rdchk(OFS_MASK_STAT, 8'h04, 8'h04);
    chk({7'h0, irq}, 8'h00);
    cmd(2'd0, 1'b1, OFS_MASK_STAT, 8'h04, 8'h00);
    repeat (3) @(negedge clk_i);
    chk({7'h0, irq}, 8'h01);
    cmd(2'd0, 1'b1, OFS_ACK_B, 8'h01, 8'h00);
    rdchk(OFS_MASK_STAT, 8'h04, 8'h00);
    cmd(2'd0, 1'b1, OFS_CTRL_HI, MODE_RATE_ADAPT, 8'h00);
    cmd(2'd0, 1'b1, OFS_MSG_TYPE, 8'h80, 8'h00);
    chk({7'h0, rf}, 8'h01);
    cmd(2'd0, 1'b1, OFS_SRST, 8'h01, 8'h00);
    rdchk(OFS_SRST, 8'h01, 8'h01);
    chk({6'h0, crst, rxr}, 8'h02);
    cmd(2'd0, 1'b1, OFS_SRST, 8'h00, 8'h00);
    cmd(2'd2, 1'b1, OFS_SRST, 8'h01, 8'h00);
    rxmsg(2, 8'hc0);
    repeat (4) @(negedge clk_i);
    chk({6'h0, crst, irq}, 8'h00);
    rdchk(OFS_ACK_A, 8'h01, 8'h01);
    conclude();
  end
endmodule // hmb_tb_top
`default_nettype wire
